// file: dv/dsa_chk.sv
// Port-level assertions for the dual data-space access unit
`default_nettype none

module dsa_chk (
    input wire logic              core_clk,
    input wire logic              reset,
    input wire dsa_pkg::x_req_s   x_req,
    input wire dsa_pkg::y_req_s   y_req,
    input wire logic       [15:0] x_prefetch_ptr_a,
    input wire logic       [15:0] x_prefetch_ptr_b,
    input wire logic       [15:0] y_prefetch_ptr_a,
    input wire logic       [15:0] y_prefetch_ptr_b,
    input wire dsa_pkg::mod_cfg_s y_mod,
    input wire dsa_pkg::sfr_cmd_s sfr_cmd,
    input wire dsa_pkg::x_resp_s  x_resp,
    input wire dsa_pkg::y_resp_s  y_resp,
    input wire logic              address_error
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] x_pf;
    logic [15:0] y_ea;
    logic        x_pref;
    logic        x_mis;
    logic        fault_reg;

    assign x_pref = x_req.mode == dsa_pkg::MODE_PREFETCH;
    assign x_pf   = x_req.pf_sel_b ? x_prefetch_ptr_b : x_prefetch_ptr_a;
    assign y_ea   = y_req.sel_b ? y_prefetch_ptr_b : y_prefetch_ptr_a;
    assign x_mis  = x_req.valid && (x_pref ? x_pf[0] : !x_req.byte_op && sfr_cmd.addr[0]);

    // Misaligned word access taken at the previous edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= x_mis || (y_req.valid && y_ea[0]);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    rd_answer_a: assert property (x_req.valid && (!x_req.write || x_pref) |=> x_resp.rvalid)
        else $error("X read not answered");
    idle_quiet_a: assert property (!x_req.valid |-> sfr_cmd.wr_be == dsa_pkg::BE_NONE && !sfr_cmd.rd)
        else $error("Register bus active while idle");
    pf_nowrite_a: assert property (x_req.valid && x_pref |-> sfr_cmd.wr_be == dsa_pkg::BE_NONE)
        else $error("Prefetch wrote");
    byte_lane_a: assert property (x_req.valid && x_req.write && x_req.byte_op && !x_pref
        && sfr_cmd.addr <= dsa_pkg::SFR_LAST |-> sfr_cmd.wr_be == (sfr_cmd.addr[0] ? 2'h2 : 2'h1))
        else $error("Wrong byte lane");
    mis_wr_a: assert property (x_mis && x_req.write && !x_pref |-> sfr_cmd.wr_be == dsa_pkg::BE_NONE)
        else $error("Misaligned write not suppressed");
    err_match_a: assert property (address_error == fault_reg)
        else $error("Address error pulse wrong");
    y_zero_a: assert property (y_req.valid && (y_ea < dsa_pkg::Y_FIRST || y_ea > dsa_pkg::Y_LAST)
        |=> y_resp.rvalid && y_resp.rdata == dsa_pkg::ZERO_WORD)
        else $error("Y fetch outside Y not zero");
    byte_read_a: assert property (x_req.valid && !x_req.write && x_req.byte_op && !x_pref
        |=> x_resp.rdata[15:8] == 8'h00)
        else $error("Byte read high lane not zero");
    near_ea_a: assert property (x_req.valid && x_req.mode == dsa_pkg::MODE_NEAR
        |-> sfr_cmd.addr == {3'h0, x_req.direct_addr[12:0]})
        else $error("Near address wrong");
    y_step_a: assert property (y_req.valid && y_req.post == dsa_pkg::POST_INC && !y_mod.en
        |=> y_resp.ptr_upd && y_resp.ptr_next == $past(y_ea) + dsa_pkg::WORD_STEP)
        else $error("Y step wrong");

    cover property (address_error);
    cover property (x_resp.rvalid && y_resp.rvalid);
    cover property (x_req.valid && x_req.write && x_req.byte_op);

endmodule // dsa_chk

bind dual_data_space_access_unit dsa_chk dsa_chk_inst (
    .core_clk(core_clk), .reset(reset), .x_req(x_req), .y_req(y_req),
    .x_prefetch_ptr_a(x_prefetch_ptr_a), .x_prefetch_ptr_b(x_prefetch_ptr_b),
    .y_prefetch_ptr_a(y_prefetch_ptr_a), .y_prefetch_ptr_b(y_prefetch_ptr_b),
    .y_mod(y_mod), .sfr_cmd(sfr_cmd), .x_resp(x_resp), .y_resp(y_resp), .address_error(address_error)
);

`default_nettype wire

// file: dv/dual_data_space_access_unit_bench.sv
// Self-checking bench for the dual data-space access unit
`default_nettype none

module dual_data_space_access_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                core_clk;
    logic                reset;
    dsa_pkg::x_req_s     x_req;
    dsa_pkg::y_req_s     y_req;
    dsa_pkg::y_req_s     y_next;
    logic         [15:0] xpa;
    logic         [15:0] xpb;
    logic         [15:0] ypa;
    logic         [15:0] ypb;
    dsa_pkg::mod_cfg_s   x_mod;
    dsa_pkg::mod_cfg_s   y_mod;
    logic         [15:0] bitrev_mod;
    dsa_pkg::sfr_cmd_s   sfr_cmd;
    logic         [15:0] sfr_rdata;
    dsa_pkg::x_resp_s    x_resp;
    dsa_pkg::y_resp_s    y_resp;
    logic                address_error;
    logic                brev;
    int                  errors;
    int                  n_checks;

    dual_data_space_access_unit dual_data_space_access_unit_inst (
        .core_clk(core_clk), .reset(reset), .x_req(x_req), .y_req(y_req),
        .x_prefetch_ptr_a(xpa), .x_prefetch_ptr_b(xpb), .y_prefetch_ptr_a(ypa), .y_prefetch_ptr_b(ypb),
        .x_mod(x_mod), .y_mod(y_mod), .bitrev_mod(bitrev_mod), .sfr_cmd(sfr_cmd), .sfr_rdata(sfr_rdata),
        .x_resp(x_resp), .y_resp(y_resp), .address_error(address_error)
    );

    sfr_model sfr_model_inst (.core_clk(core_clk), .sfr_cmd(sfr_cmd), .sfr_rdata(sfr_rdata));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One X request with the staged Y request; mode 0 ind 1 near 2 abs 3 prefetch, post 0 none 1 inc 2 dec
    task automatic xo(input logic w, input logic bt, input logic [1:0] m, input logic [1:0] p,
                      input logic [15:0] a, input logic [15:0] d);
        dsa_pkg::x_req_s r;
        r = '0;
        r.valid = 1'h1;
        r.write = w;
        r.byte_op = bt;
        r.pf_sel_b = a[0];
        r.mode = dsa_pkg::addr_mode_e'(m);
        r.post = dsa_pkg::post_mod_e'(p);
        r.bitrev_en = brev;
        r.ptr = a;
        r.direct_addr = a;
        r.wdata = d;
        r.dest_old = 16'h5566;
        @(posedge core_clk);
        x_req <= r;
        y_req <= y_next;
        @(posedge core_clk);
        x_req <= '0;
        y_req <= '0;
        #1;
    endtask

    task automatic s_word();
        xo(1'h1, 1'h0, 2'h0, 2'h1, 16'h0802, 16'h1234);
        chk(x_resp.ptr_next, 16'h0804);
        chk({15'h0000, x_resp.ptr_upd}, 16'h0001);
        xo(1'h0, 1'h0, 2'h0, 2'h2, 16'h0802, 16'h0000);
        chk(x_resp.rdata, 16'h1234);
        chk(x_resp.ptr_next, 16'h0800);
    endtask

    task automatic s_byte();
        xo(1'h1, 1'h1, 2'h0, 2'h1, 16'h0803, 16'h00ab);
        chk(x_resp.ptr_next, 16'h0804);
        xo(1'h0, 1'h0, 2'h2, 2'h0, 16'h0802, 16'h0000);
        chk(x_resp.rdata, 16'hab34);
        xo(1'h0, 1'h1, 2'h2, 2'h0, 16'h0803, 16'h0000);
        chk(x_resp.rdata, 16'h00ab);
        chk(x_resp.load_data, 16'h55ab);
    endtask

    // Mid-run reset clears every held answer; RAM keeps its contents
    task automatic s_reset();
        @(posedge core_clk);
        reset <= 1'h1;
        @(posedge core_clk);
        reset <= 1'h0;
        #1;
        chk(x_resp.load_data, 16'h0000);
        chk(x_resp.ptr_next, 16'h0000);
        chk({15'h0000, address_error}, 16'h0000);
    endtask

    task automatic s_misalign();
        xo(1'h1, 1'h0, 2'h2, 2'h0, 16'h0804, 16'h0f0f);
        xo(1'h1, 1'h0, 2'h2, 2'h0, 16'h0805, 16'hffff);
        chk({15'h0000, address_error}, 16'h0001);
        @(posedge core_clk);
        #1;
        chk({15'h0000, address_error}, 16'h0000);
        xo(1'h0, 1'h0, 2'h2, 2'h0, 16'h0805, 16'h0000);
        chk(x_resp.rdata, 16'h0f0f);
        chk({15'h0000, x_resp.rvalid & address_error}, 16'h0001);
    endtask

    task automatic s_space();
        xo(1'h1, 1'h0, 2'h2, 2'h0, 16'h0800, 16'h4321);
        xo(1'h1, 1'h0, 2'h2, 2'h0, 16'h0a00, 16'hbeef);
        xo(1'h0, 1'h0, 2'h2, 2'h0, 16'h0a00, 16'h0000);
        chk(x_resp.rdata, 16'h0000);
        xo(1'h0, 1'h0, 2'h2, 2'h0, 16'h0800, 16'h0000);
        chk(x_resp.rdata, 16'h4321);
        xo(1'h0, 1'h0, 2'h2, 2'h0, 16'hfffe, 16'h0000);
        chk(x_resp.rdata, 16'h0000);
        xo(1'h1, 1'h0, 2'h2, 2'h0, 16'h0900, 16'h7777);
        xo(1'h0, 1'h0, 2'h0, 2'h0, 16'h0900, 16'h0000);
        chk(x_resp.rdata, 16'h7777);
        xo(1'h0, 1'h0, 2'h1, 2'h0, 16'he802, 16'h0000);
        chk(x_resp.rdata, 16'hab34);
        xo(1'h0, 1'h0, 2'h2, 2'h0, 16'he802, 16'h0000);
        chk(x_resp.rdata, 16'h0000);
    endtask

    task automatic s_prefetch();
        @(posedge core_clk);
        xpa <= 16'h0900;
        xpb <= 16'h0802;
        ypa <= 16'h0900;
        ypb <= 16'h0802;
        y_next = '{1'h1, 1'h0, dsa_pkg::POST_INC};
        xo(1'h1, 1'h0, 2'h3, 2'h0, 16'h0000, 16'h0000);
        chk(x_resp.rdata, 16'h0000);
        chk(y_resp.rdata, 16'h7777);
        chk({15'h0000, x_resp.rvalid & y_resp.rvalid}, 16'h0001);
        chk(y_resp.ptr_next, 16'h0902);
        y_next.sel_b = 1'h1;
        xo(1'h0, 1'h0, 2'h3, 2'h0, 16'h0001, 16'h0000);
        chk(x_resp.rdata, 16'hab34);
        chk(y_resp.rdata, 16'h0000);
        y_next = '0;
    endtask

    task automatic s_modulo();
        @(posedge core_clk);
        x_mod <= '{1'h1, 16'h0800, 16'h0807};
        y_mod <= '{1'h1, 16'h0900, 16'h0903};
        ypa <= 16'h0902;
        ypb <= 16'h0900;
        bitrev_mod <= 16'h0008;
        y_next = '{1'h1, 1'h0, dsa_pkg::POST_INC};
        xo(1'h0, 1'h0, 2'h0, 2'h1, 16'h0806, 16'h0000);
        chk(y_resp.ptr_next, 16'h0900);
        chk(x_resp.ptr_next, 16'h0800);
        y_next = '{1'h1, 1'h1, dsa_pkg::POST_DEC};
        xo(1'h0, 1'h0, 2'h0, 2'h2, 16'h0800, 16'h0000);
        chk(y_resp.ptr_next, 16'h0902);
        chk(x_resp.ptr_next, 16'h0806);
        y_next = '0;
        brev = 1'h1;
        xo(1'h1, 1'h0, 2'h0, 2'h1, 16'h0808, 16'h0000);
        chk(x_resp.ptr_next, 16'h0804);
        xo(1'h0, 1'h0, 2'h0, 2'h1, 16'h0808, 16'h0000);
        chk(x_resp.ptr_next, 16'h080a);
        brev = 1'h0;
    endtask

    task automatic s_sfr();
        xo(1'h1, 1'h1, 2'h2, 2'h0, 16'h0011, 16'h00cd);
        xo(1'h1, 1'h1, 2'h2, 2'h0, 16'h0010, 16'h0012);
        xo(1'h0, 1'h0, 2'h2, 2'h0, 16'h0010, 16'h0000);
        chk(x_resp.rdata, 16'hcd12);
    endtask

    initial begin
        errors = 0;
        n_checks = 0;
        brev = 1'h0;
        reset = 1'h1;
        x_req = '0;
        y_req = '0;
        y_next = '0;
        xpa = 16'h0000;
        xpb = 16'h0000;
        ypa = 16'h0000;
        ypb = 16'h0000;
        x_mod = '0;
        y_mod = '0;
        bitrev_mod = 16'h0000;
        repeat (4) @(posedge core_clk);
        reset <= 1'h0;
        s_word();
        s_byte();
        s_reset();
        s_misalign();
        s_space();
        s_prefetch();
        s_modulo();
        s_sfr();
        stop_test();
    end

    // About sixty cycles of traffic; over sixty times that is a hang
    initial begin
        #40000;
        errors++;
        stop_test();
    end

endmodule // dual_data_space_access_unit_bench

`default_nettype wire

// file: dv/sfr_model.sv
// Special function register responder on the far side of the X bus
`default_nettype none

module sfr_model (
    input  wire logic              core_clk,
    input  wire dsa_pkg::sfr_cmd_s sfr_cmd,
    output logic            [15:0] sfr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] regs [16] = '{default: 16'h0000};
    logic [15:0] idle_pat  = 16'h5a5a;

    // Unselected bus shows a toggling pattern, never stale data
    assign sfr_rdata = sfr_cmd.rd ? regs[sfr_cmd.addr[4:1]] : idle_pat;

    // Shared word decode, one write line per byte
    always_ff @(posedge core_clk) begin
        idle_pat <= ~idle_pat;
        if (sfr_cmd.wr_be[0]) begin
            regs[sfr_cmd.addr[4:1]][7:0] <= sfr_cmd.wdata[7:0];
        end
        if (sfr_cmd.wr_be[1]) begin
            regs[sfr_cmd.addr[4:1]][15:8] <= sfr_cmd.wdata[15:8];
        end
    end

endmodule // sfr_model

`default_nettype wire

// file: hdl/addr_step.sv
// Pointer post-modification: size scaling, modulo wrap, bit-reversed carry
`default_nettype none

module addr_step #(
    parameter bit BITREV_OK = 1'b1
) (
    input  wire logic                [15:0] ptr,
    input  wire logic                       byte_op,
    input  wire dsa_pkg::post_mod_e         post,
    input  wire dsa_pkg::mod_cfg_s          modcfg,
    input  wire logic                       bitrev_en,
    input  wire logic                [15:0] bitrev_mod,
    output logic                     [15:0] ptr_next
);

    logic [15:0] ptr_rev;
    logic [15:0] mod_rev;
    logic [15:0] sum_rev;
    logic [15:0] br_next;
    logic [15:0] step;
    logic [15:0] last_fit;

    // Bit-reversed addressing adds with the carry running downward
    for (genvar i = 0; i < 16; i++) begin : g_rev
        assign ptr_rev[i] = ptr[15 - i];
        assign mod_rev[i] = bitrev_mod[15 - i];
        assign br_next[i] = sum_rev[15 - i];
    end
    assign sum_rev = ptr_rev + mod_rev;

    always_comb begin
        step     = byte_op ? dsa_pkg::BYTE_STEP : dsa_pkg::WORD_STEP;
        last_fit = modcfg.last - step + dsa_pkg::BYTE_STEP;
        case (post)
            dsa_pkg::POST_INC: begin
                if (BITREV_OK && bitrev_en) begin
                    ptr_next = br_next;
                end else if (modcfg.en && ptr >= last_fit && ptr <= modcfg.last) begin
                    ptr_next = modcfg.first;
                end else begin
                    ptr_next = ptr + step;
                end
            end
            dsa_pkg::POST_DEC: begin
                if (modcfg.en && ptr == modcfg.first) begin
                    ptr_next = last_fit;
                end else begin
                    ptr_next = ptr - step;
                end
            end
            default: begin
                ptr_next = ptr;
            end
        endcase
    end

endmodule // addr_step

`default_nettype wire

// file: hdl/byte_lane.sv
// Byte lane selection for reads, register loads and write enables
`default_nettype none

module byte_lane (
    input  wire logic [15:0] word_in,
    input  wire logic        ea_lsb,
    input  wire logic        byte_op,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] dest_old,
    output logic      [15:0] rd_val,
    output logic      [15:0] load_val,
    output logic      [1:0]  wr_be,
    output logic      [15:0] wr_data
);

    logic [7:0] sel_byte;

    assign sel_byte = ea_lsb ? word_in[15:8] : word_in[7:0];
    assign rd_val   = byte_op ? {8'h00, sel_byte} : word_in;
    assign load_val = byte_op ? {dest_old[15:8], sel_byte} : word_in;

    for (genvar l = 0; l < dsa_pkg::LANES; l++) begin : g_lane
        // Byte write lands on the lane named by the address bit
        assign wr_be[l] = !byte_op || (ea_lsb == l[0]);
        assign wr_data[l*dsa_pkg::LANE_W +: dsa_pkg::LANE_W] = byte_op ? wdata[7:0]
                                                            : wdata[l*dsa_pkg::LANE_W +: dsa_pkg::LANE_W];
    end

endmodule // byte_lane

`default_nettype wire

// file: hdl/dual_data_space_access_unit.sv
// Dual data-space access unit: X read/write path, Y prefetch path, data RAM
`default_nettype none

module dual_data_space_access_unit #(
    parameter int unsigned RAM_WORDS = dsa_pkg::RAM_WORDS
) (
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire dsa_pkg::x_req_s         x_req,
    input  wire dsa_pkg::y_req_s         y_req,
    input  wire logic             [15:0] x_prefetch_ptr_a,
    input  wire logic             [15:0] x_prefetch_ptr_b,
    input  wire logic             [15:0] y_prefetch_ptr_a,
    input  wire logic             [15:0] y_prefetch_ptr_b,
    input  wire dsa_pkg::mod_cfg_s       x_mod,
    input  wire dsa_pkg::mod_cfg_s       y_mod,
    input  wire logic             [15:0] bitrev_mod,
    output dsa_pkg::sfr_cmd_s            sfr_cmd,
    input  wire logic             [15:0] sfr_rdata,
    output dsa_pkg::x_resp_s             x_resp,
    output dsa_pkg::y_resp_s             y_resp,
    output logic                         address_error
);

    localparam int unsigned IDX_W = $clog2(RAM_WORDS);

    // RAM read words assembled from the two byte-lane arrays
    logic [15:0] x_ram_word;
    logic [15:0] y_ram_word;

    logic [15:0]      x_ptr_sel;
    logic [15:0]      x_ea;
    logic [15:0]      y_ea;
    logic [15:0]      x_off;
    logic [15:0]      y_off;
    logic [IDX_W-1:0] x_idx;
    logic [IDX_W-1:0] y_idx;
    logic             x_is_write;
    logic             x_in_ram;
    logic             x_in_sfr;
    logic             x_in_y;
    logic             y_in_y;
    logic             x_zero;
    logic             x_misalign;
    logic             y_misalign;
    logic             x_ptr_mod;
    logic             ram_wr;
    logic [15:0]      x_word;
    logic [15:0]      y_word;
    logic [15:0]      x_rd_val;
    logic [15:0]      x_load_val;
    logic [1:0]       x_be;
    logic [15:0]      x_wr_data;
    logic [15:0]      x_ptr_next;
    logic [15:0]      y_ptr_next;

    logic             x_rvalid_reg;
    logic             x_ptr_upd_reg;
    logic [15:0]      x_rdata_reg;
    logic [15:0]      x_load_data_reg;
    logic [15:0]      x_ptr_next_reg;
    logic             y_rvalid_reg;
    logic             y_ptr_upd_reg;
    logic [15:0]      y_rdata_reg;
    logic [15:0]      y_ptr_next_reg;
    logic             address_error_reg;

    // Region decode against constant bounds only
    function automatic logic in_ram_f(input logic [15:0] a);
        in_ram_f = (a >= dsa_pkg::RAM_FIRST) && (a <= dsa_pkg::RAM_LAST);
    endfunction

    function automatic logic in_y_f(input logic [15:0] a);
        in_y_f = (a >= dsa_pkg::Y_FIRST) && (a <= dsa_pkg::Y_LAST);
    endfunction

    // X effective address
    always_comb begin
        case (x_req.mode)
            dsa_pkg::MODE_PREFETCH: begin
                x_ptr_sel = x_req.pf_sel_b ? x_prefetch_ptr_b : x_prefetch_ptr_a;
            end
            default: begin
                x_ptr_sel = x_req.ptr;
            end
        endcase
    end

    always_comb begin
        case (x_req.mode)
            dsa_pkg::MODE_NEAR: begin
                x_ea = {3'h0, x_req.direct_addr[dsa_pkg::NEAR_W-1:0]};
            end
            dsa_pkg::MODE_ABS: begin
                x_ea = x_req.direct_addr;
            end
            default: begin
                x_ea = x_ptr_sel;
            end
        endcase
    end

    // Y effective address; Y pointers only, never the X ones
    assign y_ea = y_req.sel_b ? y_prefetch_ptr_b : y_prefetch_ptr_a;

    // Prefetch mode is read-only; every write goes through here
    assign x_is_write = x_req.write && (x_req.mode != dsa_pkg::MODE_PREFETCH);

    assign x_in_ram = in_ram_f(x_ea);
    assign x_in_sfr = (x_ea <= dsa_pkg::SFR_LAST);
    assign x_in_y   = in_y_f(x_ea);
    assign y_in_y   = in_y_f(y_ea);

    // Combined space unless fetching through an X prefetch pointer
    assign x_zero = !(x_in_ram || x_in_sfr)
                    || (x_req.mode == dsa_pkg::MODE_PREFETCH && x_in_y);

    assign x_misalign = x_req.valid && !x_req.byte_op && x_ea[0];
    assign y_misalign = y_req.valid && y_ea[0];

    assign x_off = x_ea - dsa_pkg::RAM_FIRST;
    assign y_off = y_ea - dsa_pkg::RAM_FIRST;
    assign x_idx = x_off[IDX_W:1];
    assign y_idx = y_off[IDX_W:1];

    // Two concurrent read ports: X and Y
    assign y_word = y_in_y ? y_ram_word : dsa_pkg::ZERO_WORD;

    always_comb begin
        if (x_zero) begin
            x_word = dsa_pkg::ZERO_WORD;
        end else if (x_in_sfr) begin
            x_word = sfr_rdata;
        end else begin
            x_word = x_ram_word;
        end
    end

    byte_lane u_byte_lane (
        .word_in  (x_word),
        .ea_lsb   (x_ea[0]),
        .byte_op  (x_req.byte_op),
        .wdata    (x_req.wdata),
        .dest_old (x_req.dest_old),
        .rd_val   (x_rd_val),
        .load_val (x_load_val),
        .wr_be    (x_be),
        .wr_data  (x_wr_data)
    );

    // Accumulator write-back is an ordinary X write: no Y exclusion here
    assign ram_wr = x_req.valid && x_is_write && x_in_ram && !x_misalign;

    for (genvar l = 0; l < dsa_pkg::LANES; l++) begin : g_ram_lane
        // One byte-wide array per lane; both lanes share the word decode
        logic [dsa_pkg::LANE_W-1:0] lane_mem [RAM_WORDS];

        always_ff @(posedge core_clk) begin
            if (ram_wr && x_be[l]) begin
                lane_mem[x_idx] <= x_wr_data[l*dsa_pkg::LANE_W +: dsa_pkg::LANE_W];
            end
        end

        assign x_ram_word[l*dsa_pkg::LANE_W +: dsa_pkg::LANE_W] = lane_mem[x_idx];
        assign y_ram_word[l*dsa_pkg::LANE_W +: dsa_pkg::LANE_W] = lane_mem[y_idx];
    end

    // Special function register side of the X buses
    always_comb begin
        sfr_cmd       = '0;
        sfr_cmd.addr  = x_ea;
        sfr_cmd.wdata = x_wr_data;
        sfr_cmd.rd    = x_req.valid && !x_is_write && x_in_sfr;
        sfr_cmd.wr_be = (x_req.valid && x_is_write && x_in_sfr && !x_misalign) ? x_be
                                                                            : dsa_pkg::BE_NONE;
    end

    // Pointer arithmetic for X and Y
    assign x_ptr_mod = (x_req.mode == dsa_pkg::MODE_INDIRECT || x_req.mode == dsa_pkg::MODE_PREFETCH)
                       && (x_req.post != dsa_pkg::POST_NONE);

    addr_step #(
        .BITREV_OK (1'b1)
    ) u_x_step (
        .ptr        (x_ptr_sel),
        .byte_op    (x_req.byte_op),
        .post       (x_req.post),
        .modcfg     (x_mod),
        .bitrev_en  (x_req.bitrev_en && x_is_write),
        .bitrev_mod (bitrev_mod),
        .ptr_next   (x_ptr_next)
    );

    addr_step #(
        .BITREV_OK (1'b0)
    ) u_y_step (
        .ptr        (y_ea),
        .byte_op    (1'b0),
        .post       (y_req.post),
        .modcfg     (y_mod),
        .bitrev_en  (1'b0),
        .bitrev_mod (bitrev_mod),
        .ptr_next   (y_ptr_next)
    );

    // X read and pointer-update strobes, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (reset) begin
            x_rvalid_reg  <= 1'h0;
            x_ptr_upd_reg <= 1'h0;
        end else begin
            x_rvalid_reg  <= x_req.valid && !x_is_write;
            x_ptr_upd_reg <= x_req.valid && x_ptr_mod;
        end
    end

    // X read data holds until the next read
    always_ff @(posedge core_clk) begin
        if (reset) begin
            x_rdata_reg     <= dsa_pkg::ZERO_WORD;
            x_load_data_reg <= dsa_pkg::ZERO_WORD;
        end else if (x_req.valid && !x_is_write) begin
            x_rdata_reg     <= x_rd_val;
            x_load_data_reg <= x_load_val;
        end
    end

    // Updated X pointer holds until the next update
    always_ff @(posedge core_clk) begin
        if (reset) begin
            x_ptr_next_reg <= dsa_pkg::ZERO_WORD;
        end else if (x_req.valid && x_ptr_mod) begin
            x_ptr_next_reg <= x_ptr_next;
        end
    end

    // Y read and pointer-update strobes, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (reset) begin
            y_rvalid_reg  <= 1'h0;
            y_ptr_upd_reg <= 1'h0;
        end else begin
            y_rvalid_reg  <= y_req.valid;
            y_ptr_upd_reg <= y_req.valid && (y_req.post != dsa_pkg::POST_NONE);
        end
    end

    // Y prefetch data holds until the next prefetch
    always_ff @(posedge core_clk) begin
        if (reset) begin
            y_rdata_reg <= dsa_pkg::ZERO_WORD;
        end else if (y_req.valid) begin
            y_rdata_reg <= y_word;
        end
    end

    // Updated Y pointer holds until the next update
    always_ff @(posedge core_clk) begin
        if (reset) begin
            y_ptr_next_reg <= dsa_pkg::ZERO_WORD;
        end else if (y_req.valid && y_req.post != dsa_pkg::POST_NONE) begin
            y_ptr_next_reg <= y_ptr_next;
        end
    end

    // Address error: one pulse with the faulting access's answer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            address_error_reg <= 1'b0;
        end else begin
            address_error_reg <= x_misalign || y_misalign;
        end
    end

    assign x_resp        = {x_rvalid_reg, x_rdata_reg, x_load_data_reg, x_ptr_upd_reg, x_ptr_next_reg};
    assign y_resp        = {y_rvalid_reg, y_rdata_reg, y_ptr_upd_reg, y_ptr_next_reg};
    assign address_error = address_error_reg;

endmodule // dual_data_space_access_unit

`default_nettype wire

// file: include/dsa_pkg.sv
// Shared constants and carriers for the dual data-space access unit
`default_nettype none

package dsa_pkg;

    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned NEAR_W    = 13;
    localparam int unsigned LANE_W    = 8;
    localparam int unsigned LANES     = 2;
    localparam int unsigned RAM_WORDS = 256;

    localparam logic [15:0] SFR_LAST  = 16'h07ff;
    localparam logic [15:0] RAM_FIRST = 16'h0800;
    localparam logic [15:0] Y_FIRST   = 16'h0900;
    localparam logic [15:0] Y_LAST    = 16'h09ff;
    localparam logic [15:0] RAM_LAST  = 16'h09ff;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [1:0]  BE_NONE   = 2'h0;

    typedef enum logic [1:0] {MODE_INDIRECT, MODE_NEAR, MODE_ABS, MODE_PREFETCH} addr_mode_e;
    typedef enum logic [1:0] {POST_NONE, POST_INC, POST_DEC} post_mod_e;

    typedef struct packed {
        logic        en;
        logic [15:0] first;
        logic [15:0] last;
    } mod_cfg_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        byte_op;
        logic        pf_sel_b;
        addr_mode_e  mode;
        post_mod_e   post;
        logic        bitrev_en;
        logic [15:0] ptr;
        logic [15:0] direct_addr;
        logic [15:0] wdata;
        logic [15:0] dest_old;
    } x_req_s;

    typedef struct packed {
        logic      valid;
        logic      sel_b;
        post_mod_e post;
    } y_req_s;

    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
        logic [15:0] load_data;
        logic        ptr_upd;
        logic [15:0] ptr_next;
    } x_resp_s;

    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
        logic        ptr_upd;
        logic [15:0] ptr_next;
    } y_resp_s;

    typedef struct packed {
        logic        rd;
        logic [1:0]  wr_be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sfr_cmd_s;

endpackage

`default_nettype wire
